// [sim/amdct_analog_model.sv]
`default_nettype none
module amdct_analog_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control.
    input wire logic slow,
    input wire logic tx_enable,
    input wire logic adc_start,
    input wire logic [7:0] drive_level,
    // Converter result.
    output logic adc_done,
    output logic [7:0] adc_amplitude
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] wait_reg;
    logic [7:0] held_reg;
    // ========
    // Converter: amplitude equals the weight of the enabled segments.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 6'h00;
            held_reg <= 8'h00;
            adc_done <= 1'b0;
            adc_amplitude <= 8'h00;
        end else if (adc_start) begin
            wait_reg <= slow ? 6'h28 : 6'h02;
            held_reg <= tx_enable ? drive_level : 8'h00;
            adc_done <= 1'b0;
            adc_amplitude <= ~adc_amplitude;
        end else if (wait_reg != 6'h00) begin
            wait_reg <= wait_reg - 6'h01;
            adc_done <= (wait_reg == 6'h01);
            adc_amplitude <= (wait_reg == 6'h01) ? held_reg : ~adc_amplitude;
        end
    end
endmodule // amdct_analog_model
`default_nettype wire

// [sim/amdct_props.sv]
`default_nettype none
module amdct_props (
    // Clock, reset and APB.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Transmitter and converter.
    input wire logic tx_modulate,
    input wire logic tx_enable,
    input wire logic [7:0] antenna_driver_out_a,
    input wire logic [7:0] antenna_driver_out_b,
    input wire logic adc_start,
    input wire logic adc_done,
    input wire logic [7:0] adc_amplitude,
    // Tuning.
    input wire logic [3:0] auto_trim,
    input wire logic [3:0] tuning_switch_a,
    input wire logic [3:0] tuning_switch_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] trial_reg;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========
    // Trial counter of the running command.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial_reg <= 4'h0;
        end else if (!tx_enable) begin
            trial_reg <= 4'h0;
        end else if (adc_start) begin
            trial_reg <= trial_reg + 4'h1;
        end
    end
    // ========
    // Assertions.
    AST_TRIM_PAIR: assert property (tuning_switch_a == tuning_switch_b)
        else $error("tuning switch sides differ");
    AST_DRV_PAIR: assert property (antenna_driver_out_a == antenna_driver_out_b)
        else $error("driver sides differ");
    AST_START_TX_ON: assert property (adc_start |-> tx_enable)
        else $error("measurement without transmitter");
    AST_TX_FIRST: assert property ($rose(tx_enable) |-> !adc_start)
        else $error("measurement before transmitter settles");
    AST_TRIAL_GAP: assert property (adc_start |=> (!adc_start)[*8])
        else $error("trials too close");
    AST_TRIAL_COUNT: assert property ($fell(tx_enable) |-> trial_reg inside {4'h1, 4'h9})
        else $error("wrong number of measurements");
    AST_ONE_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("bus answer timing wrong");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_UNMAPPED: assert property (psel && penable && pready && (paddr > 12'h020
        || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unmapped access not refused");
    C_TRIAL: cover property (adc_start);
    C_DONE: cover property ($fell(tx_enable));
    C_ERR: cover property (pslverr);
    C_MOD: cover property (tx_modulate && antenna_driver_out_a != 8'hff);
endmodule // amdct_props
bind amdct_top amdct_props i_amdct_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_modulate(tx_modulate), .tx_enable(tx_enable), .adc_start(adc_start),
    .antenna_driver_out_a(antenna_driver_out_a), .antenna_driver_out_b(antenna_driver_out_b),
    .adc_done(adc_done), .adc_amplitude(adc_amplitude), .auto_trim(auto_trim),
    .tuning_switch_a(tuning_switch_a), .tuning_switch_b(tuning_switch_b)
);
`default_nettype wire

// [sim/tb_am_depth_calibration_tuning.sv]
`include "amdct_map.vh"
`default_nettype none
module tb_am_depth_calibration_tuning;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, er;
    logic tx_modulate, tx_enable, adc_start, adc_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, starts;
    logic [7:0] drv_a, drv_b, adc_amplitude;
    logic [3:0] auto_trim, sw_a, sw_b;
    int err_total, checks_done;
    amdct_top i_amdct_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_modulate(tx_modulate), .tx_enable(tx_enable),
        .antenna_driver_out_a(drv_a), .antenna_driver_out_b(drv_b), .adc_start(adc_start),
        .adc_done(adc_done), .adc_amplitude(adc_amplitude), .auto_trim(auto_trim),
        .tuning_switch_a(sw_a), .tuning_switch_b(sw_b));
    amdct_analog_model i_amdct_analog_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .tx_enable(tx_enable), .adc_start(adc_start), .drive_level(drv_a),
        .adc_done(adc_done), .adc_amplitude(adc_amplitude));
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        if (!presetn) begin
            starts <= 32'h0;
        end else if (adc_start === 1'b1) begin
            starts <= starts + 32'h1;
        end
    end
    // ========
    // Shared tasks.
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp && got !== exp + 32'h1 && got !== exp - 32'h1) begin
            err_total++;
            $display("BAD %0t level %h far from %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, `AMDCT_STATUS_ADDR, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 400);
        if (n >= 400) begin
            err_total++;
            report_and_stop();
        end
    endtask
    // ========
    // Scenarios.
    task automatic t_bus();
        for (int i = 0; i <= 8; i++) begin
            if (i != 7) begin
                apb(1'b0, 12'(4 * i), 32'h0);
                chk(rd, 32'h0);
            end
        end
        apb(1'b1, 12'h024, 32'hff);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h002, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, `AMDCT_DEPTH_DISP_ADDR, 32'h55);
        apb(1'b0, `AMDCT_DEPTH_DISP_ADDR, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_cal(input logic [5:0] code, input logic [7:0] norm);
        logic [31:0] amp, tgt, disp, base;
        amp = {24'h0, ~norm};
        tgt = (amp * 64) / (64 + code);
        apb(1'b1, `AMDCT_NORM_LEVEL_ADDR, {24'h0, norm});
        apb(1'b1, `AMDCT_DEPTH_CTRL_ADDR, {24'h0, 1'b0, code, 1'b0});
        base = starts;
        apb(1'b1, `AMDCT_COMMAND_ADDR, 32'h1);
        apb(1'b0, `AMDCT_STATUS_ADDR, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `AMDCT_COMMAND_ADDR, 32'h1);
        wait_done();
        chk(starts - base, 32'h9);
        chk({31'h0, tx_enable}, 32'h0);
        apb(1'b0, `AMDCT_ADC_OUT_ADDR, 32'h0);
        chk(rd, amp);
        apb(1'b0, `AMDCT_DEPTH_DISP_ADDR, 32'h0);
        disp = rd;
        chk_near(disp, tgt);
        tx_modulate <= 1'b1;
        repeat (5) @(posedge pclk);
        chk({24'h0, drv_a}, disp);
        tx_modulate <= 1'b0;
        repeat (5) @(posedge pclk);
        chk({24'h0, drv_a}, amp);
        apb(1'b1, `AMDCT_STATUS_ADDR, 32'h2);
        apb(1'b0, `AMDCT_STATUS_ADDR, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_direct();
        apb(1'b1, `AMDCT_MOD_LEVEL_ADDR, 32'h35);
        apb(1'b1, `AMDCT_DEPTH_CTRL_ADDR, 32'h80);
        tx_modulate <= 1'b1;
        repeat (5) @(posedge pclk);
        chk({24'h0, drv_a}, 32'hca);
        chk({24'h0, drv_b}, 32'hca);
        apb(1'b1, `AMDCT_AUX_DEF_ADDR, 32'h0);
        repeat (3) @(posedge pclk);
        chk({24'h0, drv_a}, 32'h0);
        apb(1'b1, `AMDCT_AUX_DEF_ADDR, 32'h1);
        tx_modulate <= 1'b0;
    endtask
    task automatic t_trim();
        logic [7:0] ctl [4];
        logic [3:0] exp [4];
        ctl = '{8'h1a, 8'h20, 8'h3a, 8'h00};
        exp = '{4'ha, 4'h5, 4'ha, 4'h0};
        auto_trim <= 4'h5;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `AMDCT_TRIM_CTRL_ADDR, {24'h0, ctl[i]});
            repeat (3) @(posedge pclk);
            chk({28'h0, sw_a}, {28'h0, exp[i]});
            chk({28'h0, sw_b}, {28'h0, exp[i]});
        end
    endtask
    task automatic t_meas();
        logic [31:0] base;
        apb(1'b1, `AMDCT_NORM_LEVEL_ADDR, 32'h33);
        base = starts;
        apb(1'b1, `AMDCT_COMMAND_ADDR, 32'h2);
        wait_done();
        chk(starts - base, 32'h1);
        apb(1'b0, `AMDCT_ADC_OUT_ADDR, 32'h0);
        chk(rd, 32'hcc);
        apb(1'b1, `AMDCT_NORM_LEVEL_ADDR, 32'h0);
    endtask
    // ========
    // Main sequence.
    initial begin
        logic [5:0] codes [6];
        codes = '{6'b001011, 6'b001110, 6'b010100, 6'b100000, 6'b110111, 6'b111111};
        {pclk, presetn, psel, penable, pwrite, tx_modulate, slow} = 7'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        auto_trim = 4'h3;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_bus();
        apb(1'b1, `AMDCT_AUX_DEF_ADDR, 32'h1);
        for (int i = 0; i < 6; i++) begin
            t_cal(codes[i], 8'h00);
        end
        slow <= 1'b1;
        t_cal(6'b001110, 8'h0f);
        slow <= 1'b0;
        t_direct();
        t_trim();
        t_meas();
        report_and_stop();
    end
endmodule // tb_am_depth_calibration_tuning
`default_nettype wire

// [src/amdct_divider.v]
`default_nettype none
// ==========================================================================
// Target level: amplitude * 64 / (64 + code), computed by restoring division.
module amdct_divider (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Request.
    input wire start,
    input wire [7:0] amplitude,
    input wire [5:0] code,
    // Result.
    output reg done,
    output reg [7:0] quotient
);
    reg [13:0] rem_reg;
    reg [7:0] quo_reg;
    reg [3:0] cnt_reg;
    reg busy_reg;
    wire [6:0] divisor = {1'b1, code};
    wire [14:0] trial = {rem_reg, 1'b0};
    wire [14:0] diff = trial - {6'h00, divisor, 2'b00};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_reg <= 14'h0000;
            quo_reg <= 8'h00;
            cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            done <= 1'b0;
            quotient <= 8'h00;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_reg <= {6'h00, amplitude};
                quo_reg <= 8'h00;
                cnt_reg <= 4'h0;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (!diff[14]) begin
                    rem_reg <= diff[13:0];
                    quo_reg <= {quo_reg[6:0], 1'b1};
                end else begin
                    rem_reg <= trial[13:0];
                    quo_reg <= {quo_reg[6:0], 1'b0};
                end
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg == 4'h7) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                    quotient <= diff[14] ? {quo_reg[6:0], 1'b0} : {quo_reg[6:0], 1'b1};
                end
            end
        end
    end
endmodule // amdct_divider
`default_nettype wire

// [src/amdct_map.vh]
`ifndef AMDCT_MAP_VH
`define AMDCT_MAP_VH
// ==========================================================================
// Register byte addresses.
`define AMDCT_DEPTH_CTRL_ADDR 12'h000
`define AMDCT_MOD_LEVEL_ADDR 12'h004
`define AMDCT_NORM_LEVEL_ADDR 12'h008
`define AMDCT_DEPTH_DISP_ADDR 12'h00c
`define AMDCT_ADC_OUT_ADDR 12'h010
`define AMDCT_TRIM_CTRL_ADDR 12'h014
`define AMDCT_AUX_DEF_ADDR 12'h018
`define AMDCT_COMMAND_ADDR 12'h01c
`define AMDCT_STATUS_ADDR 12'h020
// ==========================================================================
// Field positions.
`define AMDCT_SRC_SEL_BIT 7
`define AMDCT_CODE_MSB 6
`define AMDCT_CODE_LSB 1
`define AMDCT_TRIM_SEL_BIT 4
`define AMDCT_TRIM_AUTO_BIT 5
`define AMDCT_KEYING_BIT 0
`define AMDCT_CMD_CAL_BIT 0
`define AMDCT_CMD_MEAS_BIT 1
`define AMDCT_ST_BUSY_BIT 0
`define AMDCT_ST_DONE_BIT 1
// ==========================================================================
// Reset values.
`define AMDCT_DEPTH_CTRL_RST 8'h00
`define AMDCT_MOD_LEVEL_RST 8'h00
`define AMDCT_NORM_LEVEL_RST 8'h00
`define AMDCT_TRIM_CTRL_RST 8'h00
`define AMDCT_AUX_DEF_RST 8'h00
// ==========================================================================
// Timing: settle time after a driver change, in ns, at a 20 ns clock.
`define AMDCT_SETTLE_NS 200
`define AMDCT_CLK_NS 20
`define AMDCT_SETTLE_CYC ((`AMDCT_SETTLE_NS + `AMDCT_CLK_NS - 1) / `AMDCT_CLK_NS)
`endif

// [src/amdct_top.v]
// Chosen here: the address map and the APB interface to the registers.
`include "amdct_map.vh"
`default_nettype none
module amdct_top (
    // APB slave.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Transmitter and modulation.
    input wire tx_modulate,
    output reg tx_enable,
    output reg [7:0] antenna_driver_out_a,
    output reg [7:0] antenna_driver_out_b,
    // Amplitude converter over both receive inputs.
    output reg adc_start,
    input wire adc_done,
    input wire [7:0] adc_amplitude,
    // Tuning switches and automatic antenna calibration result.
    input wire [3:0] auto_trim,
    output reg [3:0] tuning_switch_a,
    output reg [3:0] tuning_switch_b
);
    // ======================================================================
    // State codes.
    localparam ST_IDLE = 3'd0;
    localparam ST_SETTLE = 3'd1;
    localparam ST_MEAS = 3'd2;
    localparam ST_DIV = 3'd3;
    localparam ST_TRIAL = 3'd4;
    localparam ST_TMEAS = 3'd5;
    localparam ST_DONE = 3'd6;
    localparam [7:0] SETTLE_CYC = `AMDCT_SETTLE_CYC;

    // ======================================================================
    // Registers.
    reg [7:0] depth_target_control_reg;
    reg [7:0] mod_level_reg;
    reg [7:0] norm_level_reg;
    reg [7:0] depth_disp_reg;
    reg [7:0] adc_out_reg;
    reg [7:0] trim_ctrl_reg;
    reg [7:0] aux_def_reg;
    reg [7:0] calib_reg;
    reg [7:0] target_reg;
    reg [7:0] trial_mask_reg;
    reg [7:0] best_reg;
    reg [8:0] best_err_reg;
    reg [7:0] settle_reg;
    reg [2:0] state_reg;
    reg done_flag_reg;
    reg div_start_reg;
    reg meas_busy_reg;
    reg tx_mod_s1_reg;
    reg tx_mod_s2_reg;
    reg adc_done_s1_reg;
    reg adc_done_s2_reg;
    reg adc_done_d_reg;
    wire div_done;
    wire [7:0] div_quot;
    wire depth_source_select = depth_target_control_reg[`AMDCT_SRC_SEL_BIT];
    wire [5:0] target_depth_code =
        depth_target_control_reg[`AMDCT_CODE_MSB:`AMDCT_CODE_LSB];
    wire tx_keying_select = aux_def_reg[`AMDCT_KEYING_BIT];
    wire busy = (state_reg != ST_IDLE);
    wire apb_wr = psel && penable && pwrite && pready;
    wire apb_rd = psel && !penable && !pwrite;
    wire adc_evt = adc_done_s2_reg && !adc_done_d_reg;

    // Absolute distance between a measurement and the target.
    function [8:0] amdct_dist;
        input [7:0] x;
        input [7:0] y;
        begin
            amdct_dist = (x > y) ? {1'b0, x - y} : {1'b0, y - x};
        end
    endfunction

    // Register read decode.
    function [7:0] amdct_rd;
        input [11:0] a;
        begin
            case (a)
                `AMDCT_DEPTH_CTRL_ADDR: amdct_rd = depth_target_control_reg;
                `AMDCT_MOD_LEVEL_ADDR: amdct_rd = mod_level_reg;
                `AMDCT_NORM_LEVEL_ADDR: amdct_rd = norm_level_reg;
                `AMDCT_DEPTH_DISP_ADDR: amdct_rd = depth_disp_reg;
                `AMDCT_ADC_OUT_ADDR: amdct_rd = adc_out_reg;
                `AMDCT_TRIM_CTRL_ADDR: amdct_rd = trim_ctrl_reg;
                `AMDCT_AUX_DEF_ADDR: amdct_rd = aux_def_reg;
                `AMDCT_STATUS_ADDR: amdct_rd = {6'h00, done_flag_reg, busy};
                default: amdct_rd = 8'h00;
            endcase
        end
    endfunction

    function amdct_mapped;
        input [11:0] a;
        begin
            amdct_mapped = (a <= `AMDCT_STATUS_ADDR) && (a[1:0] == 2'b00);
        end
    endfunction

    amdct_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(div_start_reg),
        .amplitude(adc_out_reg),
        .code(target_depth_code),
        .done(div_done),
        .quotient(div_quot)
    );

    // ======================================================================
    // APB slave: one wait state, read data captured in setup.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !amdct_mapped(paddr);
            if (apb_rd) begin
                prdata <= {24'h00_0000, amdct_rd(paddr)};
            end
        end
    end

    // ======================================================================
    // Software registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_target_control_reg <= `AMDCT_DEPTH_CTRL_RST;
            mod_level_reg <= `AMDCT_MOD_LEVEL_RST;
            norm_level_reg <= `AMDCT_NORM_LEVEL_RST;
            trim_ctrl_reg <= `AMDCT_TRIM_CTRL_RST;
            aux_def_reg <= `AMDCT_AUX_DEF_RST;
        end else if (apb_wr) begin
            case (paddr)
                `AMDCT_DEPTH_CTRL_ADDR: depth_target_control_reg <= pwdata[7:0];
                `AMDCT_MOD_LEVEL_ADDR: mod_level_reg <= pwdata[7:0];
                `AMDCT_NORM_LEVEL_ADDR: norm_level_reg <= pwdata[7:0];
                `AMDCT_TRIM_CTRL_ADDR: trim_ctrl_reg <= pwdata[7:0];
                `AMDCT_AUX_DEF_ADDR: aux_def_reg <= pwdata[7:0];
                default: depth_target_control_reg <= depth_target_control_reg;
            endcase
        end
    end

    // ======================================================================
    // Input synchronisers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_mod_s1_reg <= 1'b0;
            tx_mod_s2_reg <= 1'b0;
            adc_done_s1_reg <= 1'b0;
            adc_done_s2_reg <= 1'b0;
            adc_done_d_reg <= 1'b0;
        end else begin
            tx_mod_s1_reg <= tx_modulate;
            tx_mod_s2_reg <= tx_mod_s1_reg;
            adc_done_s1_reg <= adc_done;
            adc_done_s2_reg <= adc_done_s1_reg;
            adc_done_d_reg <= adc_done_s2_reg;
        end
    end

    // ======================================================================
    // Calibration and measurement sequencer.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            calib_reg <= 8'hff;
            target_reg <= 8'h00;
            trial_mask_reg <= 8'h00;
            best_reg <= 8'hff;
            best_err_reg <= 9'h1ff;
            settle_reg <= 8'h00;
            depth_disp_reg <= 8'h00;
            adc_out_reg <= 8'h00;
            done_flag_reg <= 1'b0;
            div_start_reg <= 1'b0;
            meas_busy_reg <= 1'b0;
            adc_start <= 1'b0;
        end else begin
            div_start_reg <= 1'b0;
            adc_start <= 1'b0;
            if (apb_wr && paddr == `AMDCT_STATUS_ADDR && pwdata[`AMDCT_ST_DONE_BIT]) begin
                done_flag_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (apb_wr && paddr == `AMDCT_COMMAND_ADDR) begin
                        meas_busy_reg <= pwdata[`AMDCT_CMD_MEAS_BIT] &&
                            !pwdata[`AMDCT_CMD_CAL_BIT];
                        if (pwdata[`AMDCT_CMD_CAL_BIT] || pwdata[`AMDCT_CMD_MEAS_BIT]) begin
                            calib_reg <= norm_level_reg;
                            settle_reg <= SETTLE_CYC;
                            state_reg <= ST_SETTLE;
                        end
                    end
                end
                ST_SETTLE: begin
                    settle_reg <= settle_reg - 8'd1;
                    if (settle_reg == 8'd1) begin
                        adc_start <= 1'b1;
                        state_reg <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (adc_evt) begin
                        adc_out_reg <= adc_amplitude;
                        if (meas_busy_reg) begin
                            state_reg <= ST_DONE;
                        end else begin
                            div_start_reg <= 1'b1;
                            state_reg <= ST_DIV;
                        end
                    end
                end
                ST_DIV: begin
                    if (div_done) begin
                        target_reg <= div_quot;
                        best_err_reg <= 9'h1ff;
                        calib_reg <= 8'h7f;
                        trial_mask_reg <= 8'h80;
                        settle_reg <= SETTLE_CYC;
                        state_reg <= ST_TRIAL;
                    end
                end
                ST_TRIAL: begin
                    settle_reg <= settle_reg - 8'd1;
                    if (settle_reg == 8'd1) begin
                        adc_start <= 1'b1;
                        state_reg <= ST_TMEAS;
                    end
                end
                ST_TMEAS: begin
                    if (adc_evt) begin
                        if (amdct_dist(adc_amplitude, target_reg) < best_err_reg) begin
                            best_err_reg <= amdct_dist(adc_amplitude, target_reg);
                            best_reg <= calib_reg;
                        end
                        if (adc_amplitude < target_reg) begin
                            calib_reg <= calib_reg | trial_mask_reg;
                        end
                        if (trial_mask_reg == 8'h01) begin
                            state_reg <= ST_DONE;
                        end else begin
                            calib_reg <= ((adc_amplitude < target_reg) ?
                                (calib_reg | trial_mask_reg) : calib_reg) &
                                ~(trial_mask_reg >> 1);
                            trial_mask_reg <= trial_mask_reg >> 1;
                            settle_reg <= SETTLE_CYC;
                            state_reg <= ST_TRIAL;
                        end
                    end
                end
                ST_DONE: begin
                    if (!meas_busy_reg) begin
                        depth_disp_reg <= best_reg;
                    end
                    done_flag_reg <= 1'b1;
                    meas_busy_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Driver segments and tuning switches. A set bit enables a segment.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_enable <= 1'b0;
            antenna_driver_out_a <= 8'h00;
            antenna_driver_out_b <= 8'h00;
            tuning_switch_a <= 4'h0;
            tuning_switch_b <= 4'h0;
        end else begin
            tx_enable <= busy && !(state_reg == ST_DONE);
            if (state_reg == ST_TRIAL || state_reg == ST_TMEAS) begin
                antenna_driver_out_a <= calib_reg;
                antenna_driver_out_b <= calib_reg;
            end else if (tx_mod_s2_reg && !tx_keying_select) begin
                antenna_driver_out_a <= 8'h00;
                antenna_driver_out_b <= 8'h00;
            end else if (tx_mod_s2_reg) begin
                antenna_driver_out_a <= depth_source_select ? ~mod_level_reg :
                    depth_disp_reg;
                antenna_driver_out_b <= depth_source_select ? ~mod_level_reg :
                    depth_disp_reg;
            end else begin
                antenna_driver_out_a <= ~norm_level_reg;
                antenna_driver_out_b <= ~norm_level_reg;
            end
            if (trim_ctrl_reg[`AMDCT_TRIM_SEL_BIT]) begin
                tuning_switch_a <= trim_ctrl_reg[3:0];
                tuning_switch_b <= trim_ctrl_reg[3:0];
            end else if (trim_ctrl_reg[`AMDCT_TRIM_AUTO_BIT]) begin
                tuning_switch_a <= auto_trim;
                tuning_switch_b <= auto_trim;
            end else begin
                tuning_switch_a <= 4'h0;
                tuning_switch_b <= 4'h0;
            end
        end
    end
endmodule // amdct_top
`default_nettype wire
